// [src/vrrc_params.svh]
// constants for the vector register reservation and chaining block
`ifndef VRRC_PARAMS_SVH
`define VRRC_PARAMS_SVH
`define VRRC_NV 8
`define VRRC_RW 3
`define VRRC_EW 7
`define VRRC_CW 8
`define VRRC_DW 32
`define VRRC_MEMW 10
`define VRRC_MAX_COUNT 8'h80
`define VRRC_COUNT_RST 8'h80
`define VRRC_PAIR 8'h02
`define VRRC_OFS_ISSUE 8'h00
`define VRRC_OFS_COUNT 8'h04
`define VRRC_OFS_BASE 8'h08
`define VRRC_OFS_STRIDE 8'h0C
`define VRRC_OFS_SCALAR 8'h10
`define VRRC_OFS_ESEL 8'h14
`define VRRC_OFS_EDATA 8'h18
`define VRRC_OFS_STATUS 8'h1C
`define VRRC_OFS_PROG 8'h20
`define VRRC_ISS_OP 1:0
`define VRRC_ISS_DST 6:4
`define VRRC_ISS_SRCA 10:8
`define VRRC_ISS_SRCB 14:12
`define VRRC_ESEL_IDX 6:0
`define VRRC_ESEL_REG 10:8
`endif

// [src/vrrc_pkg.sv]
// types for the vector register reservation and chaining block
package vrrc_pkg;
`include "vrrc_params.svh"

typedef enum logic [1:0] {
    VRRC_OP_LOAD = 2'b00,
    VRRC_OP_STORE = 2'b01,
    VRRC_OP_ADD = 2'b10,
    VRRC_OP_ADDS = 2'b11
} vrrc_op_t;

typedef struct packed {
    logic ack;
    logic [`VRRC_DW-1:0] rdat;
    logic [`VRRC_CW-1:0] vlen;
    logic [`VRRC_DW-1:0] base;
    logic [`VRRC_DW-1:0] stride;
    logic [`VRRC_DW-1:0] scalar;
    logic [`VRRC_EW-1:0] esel_idx;
    logic [`VRRC_RW-1:0] esel_reg;
    logic refused;
    logic [`VRRC_NV-1:0] opnd_res;
    logic [`VRRC_NV-1:0] rslt_res;
    logic m_busy;
    logic m_load;
    logic [`VRRC_RW-1:0] m_reg;
    logic [`VRRC_CW-1:0] m_len;
    logic [`VRRC_CW-1:0] m_cnt;
    logic [`VRRC_DW-1:0] m_addr;
    logic [`VRRC_DW-1:0] m_stride;
    logic req;
    logic we;
    logic pair;
    logic [`VRRC_DW-1:0] a0;
    logic [`VRRC_DW-1:0] a1;
    logic [`VRRC_DW-1:0] wd0;
    logic [`VRRC_DW-1:0] wd1;
    logic f_busy;
    logic f_uses;
    logic [`VRRC_RW-1:0] f_sa;
    logic [`VRRC_RW-1:0] f_sb;
    logic [`VRRC_RW-1:0] f_dst;
    logic [`VRRC_CW-1:0] f_len;
    logic [`VRRC_CW-1:0] f_cnt;
    logic [`VRRC_DW-1:0] f_scal;
} vrrc_state_t;
endpackage : vrrc_pkg

// [src/vrrc_top.sv]
// vector register reservation, chaining and block transfer control
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "vrrc_params.svh"

// Behaviour
// RULE1: block transfer starts at element 0, at most two words per cycle
// RULE2: transfer set up from base address, signed stride and element count
// RULE3: elements indexed 0 to 127 in each vector register
// RULE4: every vector operation starts at element 0
// RULE5: operand-reserved register blocks later use as source or destination
// RULE6: one instruction may use the same register as source and destination
// RULE7: result-reserved register may still be read by a chained instruction
// RULE8: no reservation on the element count or the scalar operand
// RULE9: scalar operand and element count are captured at issue
// RULE10: base and stride captured at issue of a memory transfer
// RULE11: memory transfer reserves the port, arithmetic reserves its unit
// RULE12: only the vector unit slot is reserved; scalar work is untouched
// RULE13: chaining may begin at whatever element the result stream reached
// RULE14: full chaining when the reader waits before element 0 arrives
// RULE15: partial chaining when the reader issues after element 0 arrived
// RULE16: chained work advances as each loaded element arrives
// RULE17: memory stall pauses the stream but keeps the chain
// RULE18: single word moves between software and one selected element
// RULE19: operation runs until processed count equals the element count
// RULE20: even and odd elements go through two parallel pipes
// RULE21: reservation released after the last counted element is done
module vrrc_top
    import vrrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mem_req,
    output logic mem_we,
    output logic mem_pair,
    output logic [31:0] mem_addr_even,
    output logic [31:0] mem_addr_odd,
    output logic [31:0] mem_wdata_even,
    output logic [31:0] mem_wdata_odd,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata_even,
    input wire logic [31:0] mem_rdata_odd
);

    vrrc_state_t s_reg;
    vrrc_state_t s_next;
    logic [31:0] vmem [0:(`VRRC_NV*128)-1];

    logic wb_req;
    logic wr;
    logic iss_try;
    logic iss_ok;
    logic esel_wr;
    logic fu_go;
    logic mem_taken;
    logic [7:0] m_pos;
    logic [`VRRC_MEMW-1:0] esel_addr;
    logic [1:0] fu_we;
    logic [1:0] ld_we;
    logic [`VRRC_MEMW-1:0] fu_idx [2];
    logic [`VRRC_MEMW-1:0] ld_idx [2];
    logic [31:0] fu_wd [2];
    logic [31:0] ld_wd [2];
    logic [31:0] st_rd [2];
    vrrc_op_t iss_op;
    logic [2:0] iss_dst;
    logic [2:0] iss_sa;
    logic [2:0] iss_sb;

    function automatic logic [31:0] merge(
        input logic [31:0] o,
        input logic [31:0] n,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // elements that must be present before the pair at pos is taken
    function automatic logic [7:0] need(
        input logic [7:0] pos,
        input logic [7:0] len
    );
        logic [7:0] nx;
        nx = pos + `VRRC_PAIR;
        return (nx > len) ? len : nx;
    endfunction : need

    // elements of register r already written by the other slot
    function automatic logic [7:0] avail(
        input vrrc_state_t s,
        input logic [2:0] r,
        input logic rdr_fu
    );
        logic [7:0] a;
        a = `VRRC_MAX_COUNT;
        if (s.rslt_res[r])
        begin
            if (rdr_fu && s.m_busy && s.m_load && s.m_reg == r)
                a = s.m_cnt; // RULE13
            else if (!rdr_fu && s.f_busy && s.f_dst == r)
                a = s.f_cnt; // RULE7
        end
        return a;
    endfunction : avail

    assign wb_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign wr = wb_req && wb_we_i;
    assign iss_try = wr && wb_adr_i == `VRRC_OFS_ISSUE;
    assign esel_wr = wr && wb_adr_i == `VRRC_OFS_EDATA;
    assign esel_addr = {s_reg.esel_reg, s_reg.esel_idx}; // RULE18
    assign iss_op = vrrc_op_t'(wb_dat_i[`VRRC_ISS_OP]);
    assign iss_dst = wb_dat_i[`VRRC_ISS_DST];
    assign iss_sa = wb_dat_i[`VRRC_ISS_SRCA];
    assign iss_sb = wb_dat_i[`VRRC_ISS_SRCB];
    assign mem_taken = s_reg.req && mem_ack;
    assign m_pos = mem_taken ? s_reg.m_cnt + `VRRC_PAIR : s_reg.m_cnt;

    // a stalled pair waits on its sources; chain never torn down
    assign fu_go = s_reg.f_busy && s_reg.f_cnt < s_reg.f_len // RULE19
        && avail(s_reg, s_reg.f_sa, 1'b1) >= need(s_reg.f_cnt, s_reg.f_len)
        && (s_reg.f_uses // RULE16
        || avail(s_reg, s_reg.f_sb, 1'b1)
        >= need(s_reg.f_cnt, s_reg.f_len)); // RULE14 RULE15

    // pipe 0 takes even elements, pipe 1 the odd ones
    for (genvar p = 0; p < 2; p++)
    begin : g_pipe
        logic [7:0] fpos;
        logic [7:0] lpos;
        logic [7:0] spos;
        assign fpos = s_reg.f_cnt + 8'(p); // RULE20
        assign lpos = s_reg.m_cnt + 8'(p);
        assign spos = m_pos + 8'(p);
        assign fu_idx[p] = {s_reg.f_dst, fpos[6:0]};
        assign fu_we[p] = fu_go && fpos < s_reg.f_len;
        assign fu_wd[p] = vmem[{s_reg.f_sa, fpos[6:0]}]
            + (s_reg.f_uses ? s_reg.f_scal : vmem[{s_reg.f_sb, fpos[6:0]}]);
        assign ld_idx[p] = {s_reg.m_reg, lpos[6:0]}; // RULE3
        assign ld_we[p] = mem_taken && s_reg.m_load && lpos < s_reg.m_len;
        assign ld_wd[p] = (p == 0) ? mem_rdata_even : mem_rdata_odd;
        assign st_rd[p] = vmem[{s_reg.m_reg, spos[6:0]}];
    end

    always_ff @(posedge core_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (fu_we[p])
                vmem[fu_idx[p]] <= fu_wd[p];
            if (ld_we[p])
                vmem[ld_idx[p]] <= ld_wd[p];
        end
        if (esel_wr)
            vmem[esel_addr] <= merge(vmem[esel_addr], wb_dat_i, wb_sel_i);
    end

    always_comb
    begin
        logic blk;
        logic [31:0] v;
        logic [31:0] ba;
        blk = 1'b0;
        v = 32'h0000_0000;
        ba = 32'h0000_0000;
        iss_ok = 1'b0;
        s_next = s_reg;
        s_next.ack = wb_req;
        s_next.rdat = 32'h0000_0000;
        if (wb_req && !wb_we_i)
        begin
            case (wb_adr_i)
                `VRRC_OFS_COUNT: s_next.rdat = {24'h00_0000, s_reg.vlen};
                `VRRC_OFS_BASE: s_next.rdat = s_reg.base;
                `VRRC_OFS_STRIDE: s_next.rdat = s_reg.stride;
                `VRRC_OFS_SCALAR: s_next.rdat = s_reg.scalar;
                `VRRC_OFS_ESEL: s_next.rdat = {21'h00_0000, s_reg.esel_reg,
                    1'b0, s_reg.esel_idx};
                `VRRC_OFS_EDATA: s_next.rdat = vmem[esel_addr];
                `VRRC_OFS_STATUS: s_next.rdat = {13'h0000, s_reg.refused,
                    s_reg.f_busy, s_reg.m_busy, s_reg.rslt_res,
                    s_reg.opnd_res};
                // an odd count's last pair steps one past the count
                `VRRC_OFS_PROG: s_next.rdat = {16'h0000, // RULE19
                    (s_reg.f_cnt > s_reg.f_len) ? s_reg.f_len : s_reg.f_cnt,
                    (s_reg.m_cnt > s_reg.m_len) ? s_reg.m_len : s_reg.m_cnt};
                default: s_next.rdat = 32'h0000_0000;
            endcase
        end
        if (wr)
        begin
            case (wb_adr_i)
                `VRRC_OFS_COUNT:
                begin
                    v = merge({24'h00_0000, s_reg.vlen}, wb_dat_i, wb_sel_i);
                    s_next.vlen = (v > 32'h0000_0080) ? `VRRC_MAX_COUNT
                        : v[7:0]; // RULE3
                end
                `VRRC_OFS_BASE:
                    s_next.base = merge(s_reg.base, wb_dat_i, wb_sel_i);
                `VRRC_OFS_STRIDE:
                    s_next.stride = merge(s_reg.stride, wb_dat_i, wb_sel_i);
                `VRRC_OFS_SCALAR:
                    s_next.scalar = merge(s_reg.scalar, wb_dat_i, wb_sel_i);
                `VRRC_OFS_ESEL:
                begin
                    v = merge({21'h00_0000, s_reg.esel_reg, 1'b0,
                        s_reg.esel_idx}, wb_dat_i, wb_sel_i);
                    s_next.esel_idx = v[`VRRC_ESEL_IDX];
                    s_next.esel_reg = v[`VRRC_ESEL_REG];
                end
                default:
                    s_next.refused = s_reg.refused;
            endcase
        end

        // progress of the arithmetic slot, two elements per cycle
        if (fu_go)
            s_next.f_cnt = s_reg.f_cnt + `VRRC_PAIR; // RULE20
        if (s_reg.f_busy && s_reg.f_cnt >= s_reg.f_len)
        begin
            s_next.f_busy = 1'b0; // RULE21
            s_next.opnd_res[s_reg.f_sa] = 1'b0;
            if (!s_reg.f_uses)
                s_next.opnd_res[s_reg.f_sb] = 1'b0;
            s_next.rslt_res[s_reg.f_dst] = 1'b0;
        end

        // memory port: a pair per request, held while memory is busy
        if (mem_taken)
        begin
            s_next.req = 1'b0;
            s_next.m_cnt = m_pos;
            s_next.m_addr = s_reg.m_addr + (s_reg.m_stride << 1);
        end
        ba = mem_taken ? s_reg.m_addr + (s_reg.m_stride << 1) : s_reg.m_addr;
        if (s_reg.m_busy && (!s_reg.req || mem_taken)
            && m_pos < s_reg.m_len // RULE19
            && (s_reg.m_load || avail(s_reg, s_reg.m_reg, 1'b0)
            >= need(m_pos, s_reg.m_len)))
        begin
            s_next.req = 1'b1; // RULE1
            s_next.we = !s_reg.m_load;
            s_next.a0 = ba;
            s_next.a1 = ba + s_reg.m_stride; // RULE2
            s_next.pair = m_pos + 8'h01 < s_reg.m_len;
            s_next.wd0 = s_reg.m_load ? 32'h0000_0000 : st_rd[0];
            s_next.wd1 = s_reg.m_load ? 32'h0000_0000 : st_rd[1];
        end
        if (s_reg.m_busy && !s_reg.req && s_reg.m_cnt >= s_reg.m_len)
        begin
            s_next.m_busy = 1'b0; // RULE21
            if (s_reg.m_load)
                s_next.rslt_res[s_reg.m_reg] = 1'b0;
            else
                s_next.opnd_res[s_reg.m_reg] = 1'b0;
        end

        // issue check against the state before this cycle's release
        if (iss_try)
        begin
            case (iss_op)
                VRRC_OP_LOAD:
                    blk = s_reg.m_busy || s_reg.opnd_res[iss_dst]
                        || s_reg.rslt_res[iss_dst]; // RULE5
                VRRC_OP_STORE:
                    blk = s_reg.m_busy || s_reg.opnd_res[iss_dst]; // RULE7
                VRRC_OP_ADD:
                    blk = s_reg.f_busy || s_reg.opnd_res[iss_sa]
                        || s_reg.opnd_res[iss_sb] || s_reg.opnd_res[iss_dst]
                        || s_reg.rslt_res[iss_dst]; // RULE6
                default:
                    blk = s_reg.f_busy || s_reg.opnd_res[iss_sa]
                        || s_reg.opnd_res[iss_dst]
                        || s_reg.rslt_res[iss_dst]; // RULE11 RULE12
            endcase
            iss_ok = !blk;
            s_next.refused = blk;
        end
        if (iss_ok && (iss_op == VRRC_OP_LOAD || iss_op == VRRC_OP_STORE))
        begin
            s_next.m_busy = 1'b1; // RULE11
            s_next.m_load = iss_op == VRRC_OP_LOAD;
            s_next.m_reg = iss_dst;
            s_next.m_len = s_reg.vlen; // RULE9
            s_next.m_cnt = 8'h00; // RULE4
            s_next.m_addr = s_reg.base; // RULE10
            s_next.m_stride = s_reg.stride; // RULE2
            if (iss_op == VRRC_OP_LOAD)
                s_next.rslt_res[iss_dst] = 1'b1;
            else
                s_next.opnd_res[iss_dst] = 1'b1;
        end
        else if (iss_ok)
        begin
            s_next.f_busy = 1'b1;
            s_next.f_uses = iss_op == VRRC_OP_ADDS;
            s_next.f_sa = iss_sa;
            s_next.f_sb = iss_sb;
            s_next.f_dst = iss_dst;
            s_next.f_len = s_reg.vlen; // RULE8
            s_next.f_cnt = 8'h00; // RULE4
            s_next.f_scal = s_reg.scalar; // RULE9
            s_next.opnd_res[iss_sa] = 1'b1;
            if (iss_op == VRRC_OP_ADD)
                s_next.opnd_res[iss_sb] = 1'b1;
            s_next.rslt_res[iss_dst] = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.vlen <= `VRRC_COUNT_RST;
        end
        else
            s_reg <= s_next;
    end

    assign wb_dat_o = s_reg.rdat;
    assign wb_ack_o = s_reg.ack;
    assign mem_req = s_reg.req;
    assign mem_we = s_reg.we;
    assign mem_pair = s_reg.pair;
    assign mem_addr_even = s_reg.a0;
    assign mem_addr_odd = s_reg.a1;
    assign mem_wdata_even = s_reg.wd0;
    assign mem_wdata_odd = s_reg.wd1;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pair_taken;
        s_reg.req && mem_ack;
    endsequence
    sequence s_issue_blocked;
        iss_try && s_reg.opnd_res[iss_dst];
    endsequence

    ack_one_cycle_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");
    start_elem_zero_a: assert property ($rose(s_reg.m_busy) |-> // RULE4
        s_reg.m_cnt == 8'h00 && s_reg.m_addr == $past(s_reg.base))
        else $error("transfer did not start at element zero");
    two_words_a: assert property (s_pair_taken |=> // RULE1
        s_reg.m_cnt == $past(s_reg.m_cnt) + 8'h02)
        else $error("memory pair did not advance by two");
    stall_hold_a: assert property (s_reg.req && !mem_ack |=> // RULE17
        s_reg.req && $stable(s_reg.a0) && $stable(s_reg.m_cnt))
        else $error("stalled request changed");
    opnd_block_a: assert property (s_issue_blocked |=> // RULE5
        s_reg.refused
        && (s_reg.rslt_res & ~$past(s_reg.rslt_res)) == 8'h00)
        else $error("issue onto operand reserved register accepted");
    chain_gate_a: assert property (fu_go && s_reg.m_busy // RULE13
        && s_reg.m_load && s_reg.m_reg == s_reg.f_sa |->
        s_reg.m_cnt >= need(s_reg.f_cnt, s_reg.f_len))
        else $error("chained read ahead of loaded data");
    capture_op_a: assert property (s_reg.f_busy && $past(s_reg.f_busy) // RULE9
        |-> $stable(s_reg.f_len) && $stable(s_reg.f_scal))
        else $error("captured count or scalar changed in flight");
    release_res_a: assert property (s_reg.f_busy // RULE21
        && s_reg.f_cnt >= s_reg.f_len |=> !s_reg.f_busy
        && !s_reg.rslt_res[$past(s_reg.f_dst)])
        else $error("result reservation not released at end");

endmodule : vrrc_top
`default_nettype wire

// [dv/vrrc_mem_model.sv]
// central memory model answering the block's pair requests
`timescale 1ns/1ps
`default_nettype none
module vrrc_mem_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_pair,
    input wire logic [31:0] mem_addr_even,
    input wire logic [31:0] mem_addr_odd,
    input wire logic [31:0] mem_wdata_even,
    input wire logic [31:0] mem_wdata_odd,
    output logic mem_ack,
    output logic [31:0] mem_rdata_even,
    output logic [31:0] mem_rdata_odd
);
    logic [31:0] mem [0:63];
    logic [31:0] first_addr;
    logic [31:0] idle;
    logic was_req;
    logic tick;
    logic rd_ok;
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 32'h0000A000 + 32'(i);
    end
    // conflicts refuse every other cycle while stall is set
    assign mem_ack = mem_req && !(stall && tick);
    assign rd_ok = mem_req && mem_ack && !mem_we;
    // unanswered data lines toggle rather than hold old data
    assign idle = tick ? 32'hA5A5A5A5 : 32'h5A5A5A5A;
    assign mem_rdata_even = rd_ok ? mem[mem_addr_even[5:0]] : idle;
    assign mem_rdata_odd = (rd_ok && mem_pair) ? mem[mem_addr_odd[5:0]]
        : ~idle;
    always @(posedge core_clk)
    begin
        tick <= rst_n ? ~tick : 1'b0;
        was_req <= rst_n && mem_req;
        if (mem_req && !was_req)
            first_addr <= mem_addr_even;
        if (mem_req && mem_ack && mem_we)
        begin
            mem[mem_addr_even[5:0]] <= mem_wdata_even;
            if (mem_pair)
                mem[mem_addr_odd[5:0]] <= mem_wdata_odd;
        end
    end
endmodule : vrrc_mem_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the reservation and chaining block
`timescale 1ns/1ps
`default_nettype none
`include "vrrc_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb;
    logic core_clk, rst_n, cyc, stb, we, stall, ack, mreq, mwe, mpair, mack;
    logic [7:0] adr;
    logic [31:0] dat, dato, ae, ao, we0, we1, re, ro;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    vrrc_top vrrc_top_inst (.core_clk(core_clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dato), .wb_ack_o(ack),
        .mem_req(mreq), .mem_we(mwe), .mem_pair(mpair), .mem_addr_even(ae),
        .mem_addr_odd(ao), .mem_wdata_even(we0), .mem_wdata_odd(we1),
        .mem_ack(mack), .mem_rdata_even(re), .mem_rdata_odd(ro));
    vrrc_mem_model vrrc_mem_model_inst (.core_clk(core_clk), .rst_n(rst_n),
        .stall(stall), .mem_req(mreq), .mem_we(mwe), .mem_pair(mpair),
        .mem_addr_even(ae), .mem_addr_odd(ao), .mem_wdata_even(we0),
        .mem_wdata_odd(we1), .mem_ack(mack), .mem_rdata_even(re),
        .mem_rdata_odd(ro));
    always #25 core_clk = ~core_clk;
    task end_of_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            $display("unexpected at %0t: cycle limit reached", $time);
            err_total++;
            end_of_test();
        end
    end
    // one classic cycle, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // only the bench's cycle limit ends this wait
        do
        begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge core_clk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic erd(input int r, input int e, output logic [31:0] q);
        wr(`VRRC_OFS_ESEL, 32'(r * 256 + e));
        rd(`VRRC_OFS_EDATA, q);
    endtask : erd
    task automatic wait_idle;
        logic [31:0] s;
        int k;
        k = 0;
        s = 32'h00030000;
        while (s[17:16] !== 2'b00 && k < 300)
        begin
            rd(`VRRC_OFS_STATUS, s);
            k++;
        end
        `CHK(s[17:16], 2'b00)
    endtask : wait_idle
    initial
    begin
        logic [31:0] q;
        core_clk = 0;
        rst_n = 0;
        cyc = 0;
        stb = 0;
        we = 0;
        adr = 8'h00;
        dat = 32'h0;
        stall = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(`VRRC_OFS_COUNT, q);
        `CHK(q, 32'h00000080)
        rd(`VRRC_OFS_STATUS, q);
        `CHK(q, 32'h00000000)
        rd(8'hF0, q);
        `CHK(q, 32'h00000000)
        wr(`VRRC_OFS_COUNT, 32'h000000FF);
        rd(`VRRC_OFS_COUNT, q);
        `CHK(q, 32'h00000080)
        wr(`VRRC_OFS_ESEL, 32'h0000057F);
        wr(`VRRC_OFS_EDATA, 32'hCAFE0001);
        erd(5, 127, q);
        `CHK(q, 32'hCAFE0001)
        wr(`VRRC_OFS_ESEL, 32'h00000105);
        wr(`VRRC_OFS_EDATA, 32'h12345678);
        // strided load of five under conflicts, then base and stride change
        stall <= 1'b1;
        wr(`VRRC_OFS_COUNT, 32'h5);
        wr(`VRRC_OFS_BASE, 32'h4);
        wr(`VRRC_OFS_STRIDE, 32'h2);
        wr(`VRRC_OFS_ISSUE, 32'h00000010);
        wr(`VRRC_OFS_BASE, 32'h30);
        wr(`VRRC_OFS_STRIDE, 32'h7);
        wait_idle();
        `CHK(vrrc_mem_model_inst.first_addr, 32'h4)
        rd(`VRRC_OFS_PROG, q);
        `CHK(q[7:0], 8'h05)
        for (int i = 0; i < 5; i++)
        begin
            erd(1, i, q);
            `CHK(q, 32'h0000A004 + 32'(2 * i))
        end
        erd(1, 5, q);
        `CHK(q, 32'h12345678)
        // add with scalar chained onto a stalled load
        wr(`VRRC_OFS_COUNT, 32'h6);
        wr(`VRRC_OFS_BASE, 32'h0);
        wr(`VRRC_OFS_STRIDE, 32'h1);
        wr(`VRRC_OFS_SCALAR, 32'h10);
        wr(`VRRC_OFS_ISSUE, 32'h00000020);
        wr(`VRRC_OFS_ISSUE, 32'h00000233);
        rd(`VRRC_OFS_STATUS, q);
        `CHK(q[18], 1'b0)
        wr(`VRRC_OFS_SCALAR, 32'h999);
        wr(`VRRC_OFS_COUNT, 32'h2);
        rd(`VRRC_OFS_SCALAR, q);
        `CHK(q, 32'h00000999)
        wait_idle();
        for (int i = 0; i < 6; i++)
        begin
            erd(3, i, q);
            `CHK(q, 32'h0000A010 + 32'(i))
        end
        // one register as source and destination, then a blocked load
        stall <= 1'b0;
        wr(`VRRC_OFS_COUNT, 32'h80);
        wr(`VRRC_OFS_ISSUE, 32'h00001112);
        rd(`VRRC_OFS_STATUS, q);
        `CHK(q[18:16], 3'b010)
        `CHK(q[1], 1'b1)
        wr(`VRRC_OFS_ISSUE, 32'h00000010);
        rd(`VRRC_OFS_STATUS, q);
        `CHK(q[18:16], 3'b110)
        wait_idle();
        for (int i = 0; i < 5; i++)
        begin
            erd(1, i, q);
            `CHK(q, 32'h00014008 + 32'(4 * i))
        end
        // store of three with negative stride, last pair half empty
        wr(`VRRC_OFS_COUNT, 32'h3);
        wr(`VRRC_OFS_BASE, 32'h30);
        wr(`VRRC_OFS_STRIDE, 32'hFFFFFFFF);
        wr(`VRRC_OFS_ISSUE, 32'h00000031);
        wait_idle();
        for (int i = 0; i < 3; i++)
            `CHK(vrrc_mem_model_inst.mem[48 - i], 32'hA010 + 32'(i))
        `CHK(vrrc_mem_model_inst.mem[45], 32'h0000A02D)
        end_of_test();
    end
endmodule : tb
`default_nettype wire
